// *** ssq_pkg.sv ***
// package: constants, types and timing for the secure-sector and query host controller
package ssq_pkg;

  // clock rate and bus timing
  localparam int CLK_MHZ     = 20;
  localparam int T_ACC_NS    = 55;   // read access time
  localparam int T_WP_NS     = 35;   // write pulse width
  localparam int T_PROT_US   = 150;  // protect pulse width
  localparam int SYNC_STAGES = 2;
  localparam int ACC_CYC     = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES;
  localparam int WP_CYC      = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int PROT_CYC    = (T_PROT_US * CLK_MHZ);
  localparam int TMR_W       = 12;

  // command codes and addresses (word units; byte mode doubles them)
  localparam logic [18:0] UNLOCK1_ADDR = 19'h00555;
  localparam logic [18:0] UNLOCK2_ADDR = 19'h002aa;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] PROGRAM_DATA = 16'h00a0;
  localparam logic [15:0] AUTOSEL_DATA = 16'h0090;
  localparam logic [15:0] SEC_IN_DATA  = 16'h0088;
  localparam logic [15:0] SEC_OUT_DATA = 16'h0000;
  localparam logic [15:0] PROT_DATA    = 16'h0060;
  localparam logic [15:0] PROT_VFY     = 16'h0040;
  localparam logic [18:0] QUERY_ADDR   = 19'h00055;
  localparam logic [15:0] QUERY_DATA   = 16'h0098;
  localparam logic [15:0] RESET_DATA   = 16'h00f0;
  localparam logic [18:0] SEC_GRP_ADDR = 19'h0001a;
  localparam logic [18:0] QRY_ADDR_MSK = 19'h0007f;

  // serial number placement
  localparam int          ESN_WORDS    = 8;
  localparam logic [18:0] ESN_BOT_W    = 19'h00000;
  localparam logic [18:0] ESN_TOP_W    = 19'h7fff8;
  localparam logic [19:0] ESN_BOT_B    = 20'h00000;
  localparam logic [19:0] ESN_TOP_B    = 20'hffff0;

  typedef enum logic [3:0] {
    OP_READ, OP_WRITE, OP_PROGRAM, OP_QUERY, OP_RESET,
    OP_AUTOSEL, OP_SEC_ENTER, OP_SEC_EXIT, OP_ESN, OP_LOCK
  } ssq_op_e;

  typedef enum logic [1:0] {K_WR, K_RD, K_WT, K_END} ssq_kind_e;

  typedef struct packed {
    ssq_op_e     op;
    logic [18:0] addr;   // word address
    logic [15:0] data;
  } ssq_cmd_s;

  typedef struct packed {
    logic [15:0] data;
    logic        err;    // refused
    logic        ok;     // lock verified
  } ssq_rsp_s;

  typedef struct packed {
    ssq_kind_e   kind;
    logic [19:0] addr;   // pin address
    logic [15:0] data;
    logic        vid;
  } ssq_step_s;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] dq_o;
    logic        dq_oe_n;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        byte_n;
    logic        vid_req;
  } ssq_pin_s;

endpackage : ssq_pkg

// *** ssq_esn_mem.sv ***
// serial number store: small register file with registered read data
`timescale 1ns/10ps
`default_nettype none
module ssq_esn_mem #(
  parameter int DEPTH = 8,
  parameter int W     = 16
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input  wire logic [W-1:0]             wr_data,
  // read side
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic      [W-1:0]             rd_data
);
  import ssq_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            rd;
  } ssq_mem_s;

  ssq_mem_s s_r;
  ssq_mem_s s_nxt;

  // read the old contents, then write, both on the same edge
  always_comb
  begin
    s_nxt    = s_r;
    s_nxt.rd = s_r.mem[rd_idx];
    if (wr_en)
    begin
      s_nxt.mem[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rd;

endmodule : ssq_esn_mem
`default_nettype wire

// *** ssq_host.sv ***
// host controller that drives a parallel flash for secure sector and query access
// What this block does
// - full program sequence, never unlock bypass
// - lock: entry sequence, protect at 1Ah
// - exit secure region after lock verify
// - query reads keep A7 upward zero
// - reset command leaves query mode
`timescale 1ns/10ps
`default_nettype none
module ssq_host (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  // configuration straps
  input  wire logic             byte_mode,
  input  wire logic             top_boot,
  input  wire logic             factory_locked,
  // command port
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire ssq_pkg::ssq_cmd_s cmd,
  output logic                  rsp_valid,
  output ssq_pkg::ssq_rsp_s     rsp,
  // mode status
  output logic                  sec_mode,
  output logic                  query_mode,
  output logic                  sec_locked,
  // serial number read port
  input  wire logic [2:0]       esn_idx,
  output logic      [15:0]      esn_data,
  // flash pins
  output ssq_pkg::ssq_pin_s     pins,
  input  wire logic [15:0]      flash_dq_i
);
  import ssq_pkg::*;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_STEP  = 7'h02,
    S_SETUP = 7'h04,
    S_PULSE = 7'h08,
    S_HOLD  = 7'h10,
    S_WAIT  = 7'h20,
    S_RESP  = 7'h40
  } ssq_state_e;

  typedef struct packed {
    ssq_state_e       st;
    ssq_cmd_s         cmd;
    logic [4:0]       idx;
    ssq_step_s        stp;
    logic [TMR_W-1:0] tmr;
    logic [15:0]      sync1;
    logic [15:0]      sync2;
    ssq_pin_s         pin;
    ssq_rsp_s         rsp;
    logic             rsp_v;
    logic             sec;
    logic             query_signature_string;
    logic             idm;
    logic             locked;
    logic [7:0]       esn_lo;
  } ssq_ctl_s;

  ssq_ctl_s   s_r;
  ssq_ctl_s   s_nxt;
  logic       mem_we;
  logic [2:0] mem_idx;
  logic [15:0] mem_wd;

  // word address to pin address; byte mode puts A-1 in bit 0
  function automatic logic [19:0] pin_addr(input logic [18:0] wa, input logic bm);
    pin_addr = bm ? {wa, 1'b0} : {1'b0, wa};
  endfunction : pin_addr

  function automatic ssq_step_s mk(input ssq_kind_e k, input logic [18:0] wa, input logic [15:0] d,
                                   input logic bm);
    mk = '{kind: k, addr: pin_addr(wa, bm), data: d, vid: 1'b0};
  endfunction : mk

  // step list of each operation; the unlock pair opens half of them
  function automatic ssq_step_s step_of(input ssq_cmd_s c, input logic [4:0] i, input logic bm,
                                        input logic tb);
    ssq_step_s s;
    s = mk(K_END, 19'h0, 16'h0, bm);
    if (i == 5'd0 && c.op inside {OP_PROGRAM, OP_AUTOSEL, OP_SEC_ENTER, OP_SEC_EXIT, OP_LOCK})
      s = mk(K_WR, UNLOCK1_ADDR, UNLOCK1_DATA, bm);
    else if (i == 5'd1 && c.op inside {OP_PROGRAM, OP_AUTOSEL, OP_SEC_ENTER, OP_SEC_EXIT, OP_LOCK})
      s = mk(K_WR, UNLOCK2_ADDR, UNLOCK2_DATA, bm);
    else
      case (c.op)
        OP_READ:      if (i == 5'd0) s = mk(K_RD, c.addr, 16'h0, bm);
        OP_WRITE:     if (i == 5'd0) s = mk(K_WR, c.addr, c.data, bm);
        OP_PROGRAM:
        begin
          if (i == 5'd2) s = mk(K_WR, UNLOCK1_ADDR, PROGRAM_DATA, bm);
          if (i == 5'd3) s = mk(K_WR, c.addr, c.data, bm);
        end
        OP_QUERY:     if (i == 5'd0) s = mk(K_WR, QUERY_ADDR, QUERY_DATA, bm);
        OP_RESET:     if (i == 5'd0) s = mk(K_WR, 19'h0, RESET_DATA, bm);
        OP_AUTOSEL:   if (i == 5'd2) s = mk(K_WR, UNLOCK1_ADDR, AUTOSEL_DATA, bm);
        OP_SEC_ENTER: if (i == 5'd2) s = mk(K_WR, UNLOCK1_ADDR, SEC_IN_DATA, bm);
        OP_SEC_EXIT:
        begin
          if (i == 5'd2) s = mk(K_WR, UNLOCK1_ADDR, AUTOSEL_DATA, bm);
          if (i == 5'd3) s = mk(K_WR, 19'h0, SEC_OUT_DATA, bm);
        end
        // serial number window by boot side
        OP_ESN:
        begin
          if (bm && i < 5'd16)
            s = '{kind: K_RD, addr: (tb ? ESN_TOP_B : ESN_BOT_B) + {15'h0, i}, data: 16'h0, vid: 1'b0};
          else if (!bm && i < 5'(ESN_WORDS))
            s = mk(K_RD, (tb ? ESN_TOP_W : ESN_BOT_W) + {14'h0, i}, 16'h0, bm);
        end
        // entry, protect at group 1Ah, verify, exit
        OP_LOCK:
        begin
          if (i == 5'd2) s = mk(K_WR, UNLOCK1_ADDR, SEC_IN_DATA, bm);
          if (i == 5'd3) s = '{kind: K_WR, addr: pin_addr(SEC_GRP_ADDR, bm), data: PROT_DATA, vid: 1'b1};
          if (i == 5'd4) s = '{kind: K_WT, addr: pin_addr(SEC_GRP_ADDR, bm), data: 16'h0, vid: 1'b1};
          if (i == 5'd5) s = '{kind: K_WR, addr: pin_addr(SEC_GRP_ADDR, bm), data: PROT_VFY, vid: 1'b1};
          if (i == 5'd6) s = mk(K_RD, SEC_GRP_ADDR, 16'h0, bm);
          if (i == 5'd7) s = mk(K_WR, UNLOCK1_ADDR, UNLOCK1_DATA, bm);
          if (i == 5'd8) s = mk(K_WR, UNLOCK2_ADDR, UNLOCK2_DATA, bm);
          if (i == 5'd9) s = mk(K_WR, UNLOCK1_ADDR, AUTOSEL_DATA, bm);
          if (i == 5'd10) s = mk(K_WR, 19'h0, SEC_OUT_DATA, bm);
        end
        default:      s = mk(K_END, 19'h0, 16'h0, bm);
      endcase
    return s;
  endfunction : step_of

  // sequencer: one process computes the whole next state
  always_comb
  begin
    logic [15:0] rd;
    ssq_cmd_s    c;
    rd      = byte_mode ? {8'h00, s_r.sync2[7:0]} : s_r.sync2;
    c       = cmd;
    s_nxt   = s_r;
    mem_we  = 1'b0;
    mem_idx = 3'h0;
    mem_wd  = 16'h0;
    s_nxt.sync1     = flash_dq_i;
    s_nxt.sync2     = s_r.sync1;
    s_nxt.rsp_v     = 1'b0;
    s_nxt.pin.byte_n = ~byte_mode;
    case (s_r.st)
      S_IDLE:
      begin
        if (cmd_valid)
        begin
          // query reads keep high address bits zero
          if (s_r.query_signature_string && c.op == OP_READ)
            c.addr = c.addr & QRY_ADDR_MSK;
          s_nxt.cmd = c;
          s_nxt.idx = 5'd0;
          s_nxt.rsp = '0;
          s_nxt.st  = S_STEP;
          // a locked secure sector takes no program and no second lock
          if ((s_r.sec && (factory_locked || s_r.locked) && c.op inside {OP_PROGRAM, OP_WRITE})
              || (c.op == OP_LOCK && (factory_locked || s_r.locked)))
          begin
            s_nxt.rsp.err = 1'b1;
            s_nxt.st      = S_RESP;
          end
        end
      end
      S_STEP:
      begin
        s_nxt.stp = step_of(s_r.cmd, s_r.idx, byte_mode, top_boot);
        s_nxt.pin.addr    = s_nxt.stp.addr;
        s_nxt.pin.vid_req = s_nxt.stp.vid;
        s_nxt.pin.ce_n    = 1'b1;
        s_nxt.tmr         = '0;
        case (s_nxt.stp.kind)
          K_WR:
          begin
            s_nxt.pin.dq_o    = s_nxt.stp.data;
            s_nxt.pin.dq_oe_n = 1'b0;
            s_nxt.pin.ce_n    = 1'b0;
            s_nxt.st          = S_SETUP;
          end
          K_RD:
          begin
            s_nxt.pin.dq_oe_n = 1'b1;
            s_nxt.pin.ce_n    = 1'b0;
            s_nxt.st          = S_SETUP;
          end
          K_WT:
          begin
            s_nxt.tmr = TMR_W'(PROT_CYC - 1);
            s_nxt.st  = S_WAIT;
          end
          default:
          begin
            s_nxt.pin.vid_req = 1'b0;
            s_nxt.st          = S_RESP;
          end
        endcase
      end
      S_SETUP:
      begin
        // address and data settle one cycle before the strobe
        if (s_r.stp.kind == K_WR)
        begin
          s_nxt.pin.we_n = 1'b0;
          s_nxt.tmr      = TMR_W'(WP_CYC - 1);
        end
        else
        begin
          s_nxt.pin.oe_n = 1'b0;
          s_nxt.tmr      = TMR_W'(ACC_CYC - 1);
        end
        s_nxt.st = S_PULSE;
      end
      S_PULSE:
      begin
        if (s_r.tmr != '0)
          s_nxt.tmr = s_r.tmr - 1'b1;
        else
        begin
          s_nxt.pin.we_n = 1'b1;
          s_nxt.pin.oe_n = 1'b1;
          s_nxt.st       = S_HOLD;
          // the synchroniser delay is inside the access count, so sync2 is valid here
          if (s_r.stp.kind == K_RD)
          begin
            s_nxt.rsp.data = rd;
            // protect verify reads back bit 0 set
            if (s_r.cmd.op == OP_LOCK)
            begin
              s_nxt.rsp.ok = rd[0];
              s_nxt.locked = s_r.locked | rd[0];
            end
            if (s_r.cmd.op == OP_ESN)
            begin
              // byte mode pairs low then high byte
              if (byte_mode && !s_r.idx[0])
                s_nxt.esn_lo = rd[7:0];
              else
              begin
                mem_we  = 1'b1;
                mem_idx = byte_mode ? s_r.idx[3:1] : s_r.idx[2:0];
                mem_wd  = byte_mode ? {rd[7:0], s_r.esn_lo} : rd;
              end
            end
          end
        end
      end
      S_HOLD:
      begin
        // data held one cycle past the rising strobe
        s_nxt.pin.ce_n    = 1'b1;
        s_nxt.pin.dq_oe_n = 1'b1;
        s_nxt.idx         = s_r.idx + 5'd1;
        s_nxt.st          = S_STEP;
      end
      S_WAIT:
      begin
        if (s_r.tmr != '0)
          s_nxt.tmr = s_r.tmr - 1'b1;
        else
        begin
          s_nxt.idx = s_r.idx + 5'd1;
          s_nxt.st  = S_STEP;
        end
      end
      S_RESP:
      begin
        s_nxt.rsp_v = 1'b1;
        s_nxt.st    = S_IDLE;
        if (!s_r.rsp.err)
          case (s_r.cmd.op)
            OP_SEC_ENTER: s_nxt.sec = 1'b1;
            OP_SEC_EXIT,
            OP_LOCK:      s_nxt.sec = 1'b0;
            OP_QUERY:     s_nxt.query_signature_string = 1'b1;
            OP_AUTOSEL:   s_nxt.idm = 1'b1;
            // reset leaves query first, identifier mode only after
            OP_RESET:
            begin
              s_nxt.query_signature_string = 1'b0;
              if (!s_r.query_signature_string)
                s_nxt.idm = 1'b0;
            end
            default:      s_nxt.sec = s_r.sec;
          endcase
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  // all state advances only with the clock enable
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r         <= '0;
      s_r.st      <= S_IDLE;
      s_r.pin     <= '{addr: 20'h0, dq_o: 16'h0, dq_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1,
                       we_n: 1'b1, byte_n: 1'b1, vid_req: 1'b0};
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  ssq_esn_mem #(
    .DEPTH (ESN_WORDS),
    .W     (16)
  ) u_esn (
    .clock   (clock),
    .rst     (rst),
    .ce      (ce),
    .wr_en   (mem_we),
    .wr_idx  (mem_idx),
    .wr_data (mem_wd),
    .rd_idx  (esn_idx),
    .rd_data (esn_data)
  );

  // outputs
  assign cmd_ready  = (s_r.st == S_IDLE);
  assign rsp_valid  = s_r.rsp_v;
  assign rsp        = s_r.rsp;
  assign pins       = s_r.pin;
  assign sec_mode   = s_r.sec;
  assign query_mode = s_r.query_signature_string;
  assign sec_locked = s_r.locked | factory_locked;

endmodule : ssq_host
`default_nettype wire

// *** ssq_host_checker.sv ***
// assertions on the host controller ports
`timescale 1ns/10ps
`default_nettype none
module ssq_host_checker (
  // clock and reset
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              ce,
  // straps and command port
  input wire logic              byte_mode,
  input wire logic              factory_locked,
  input wire logic              cmd_valid,
  input wire logic              cmd_ready,
  input wire ssq_pkg::ssq_cmd_s cmd,
  input wire logic              rsp_valid,
  input wire ssq_pkg::ssq_rsp_s rsp,
  // status and pins
  input wire logic              sec_mode,
  input wire logic              query_mode,
  input wire logic              sec_locked,
  input wire ssq_pkg::ssq_pin_s pins
);
  import ssq_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic acc;
  // a request is taken only when the port is idle
  assign acc = ce && cmd_valid && cmd_ready;
  property p_pulse;
    rsp_valid |=> !rsp_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("response held too long");
  property p_busy;
    acc |=> !cmd_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready during a command");
  property p_lock_refused;
    acc && cmd.op == OP_LOCK && sec_locked |-> ##[1:3] rsp_valid && rsp.err;
  endproperty
  a_lock_refused: assert property (p_lock_refused) else $error("relock not refused");
  property p_prog_quiet;
    acc && cmd.op == OP_PROGRAM && sec_mode && sec_locked |=> pins.ce_n [*3];
  endproperty
  a_prog_quiet: assert property (p_prog_quiet) else $error("locked program reached pins");
  property p_byte_pin;
    !$past(rst) |-> pins.byte_n == !$past(byte_mode);
  endproperty
  a_byte_pin: assert property (p_byte_pin) else $error("bus width pin wrong");
  // a factory-locked part must never see a protect pulse request
  property p_factory;
    factory_locked |-> !pins.vid_req;
  endproperty
  a_factory: assert property (p_factory) else $error("protect pulse on factory part");
  property p_write;
    !pins.we_n |-> !pins.ce_n && !pins.dq_oe_n && pins.oe_n;
  endproperty
  a_write: assert property (p_write) else $error("write strobe without select");
  property p_qaddr;
    query_mode && !byte_mode && !pins.oe_n |-> pins.addr[19:7] == 13'h0;
  endproperty
  a_qaddr: assert property (p_qaddr) else $error("query read with high address");
endmodule : ssq_host_checker
`default_nettype wire

// *** ssq_flash_model.sv ***
// behavioural flash device answering the host's bus cycles
`timescale 1ns/10ps
`default_nettype none
module ssq_flash_model (
  // clock and straps
  input  wire logic              clock,
  input  wire logic              top_boot,
  input  wire logic              factory_locked,
  // flash pins
  input  wire ssq_pkg::ssq_pin_s pins,
  output logic [15:0]            dq
);
  import ssq_pkg::*;
  localparam logic [15:0] QT [23] = '{16'h51, 16'h52, 16'h59, 16'h2, 16'h0, 16'h40, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h0, 16'h27, 16'h36, 16'h0, 16'h0, 16'h3, 16'h0, 16'h9, 16'h0, 16'h5, 16'h0, 16'h4, 16'h0};
  logic [1:0]  step = 2'h0;
  logic        pgm = 1'b0, auto = 1'b0, query_signature_string = 1'b0, back = 1'b0, sec = 1'b0, locked = 1'b0, vfy = 1'b0;
  logic [15:0] mem [8] = '{16'ha500, 16'ha501, 16'ha502, 16'ha503, 16'ha504, 16'ha505, 16'ha506, 16'ha507};
  logic [15:0] rd, last = 16'h0;
  logic [18:0] wa;
  logic [7:0]  d;
  logic        inesn;
  // word address of a cycle; a byte bus carries one extra low bit
  assign wa = pins.byte_n ? pins.addr[18:0] : pins.addr[19:1];
  assign d  = pins.dq_o[7:0];
  // serial words sit at the boot addresses of the region
  assign inesn = top_boot ? &wa[18:3] : ~|wa[18:3];
  // command decoder acts on the rising write strobe
  always @(posedge pins.we_n)
  begin
    if (!pins.ce_n)
    begin
      step <= (wa == 19'h555 && d == 8'haa) ? 2'h1 : (step == 2'h1 && wa == 19'h2aa && d == 8'h55) ? 2'h2 : 2'h0;
      vfy  <= sec && d == 8'h40;
      // protect pulse locks only the secure group, inside the region
      if (pins.vid_req)
        locked <= locked | (sec && d == 8'h60 && wa[7:0] == 8'h1a);
      // a locked sector keeps its contents
      else if (pgm)
        mem[wa[2:0]] <= (sec && !locked && !factory_locked) ? pins.dq_o : mem[wa[2:0]];
      // reset leaves query, back to identifier mode if entered from there
      else if (d == 8'hf0)
        {auto, query_signature_string} <= {query_signature_string & back, 1'b0};
      // query entry at word 55h or byte AAh
      else if (wa == 19'h55 && d == 8'h98)
        {back, query_signature_string} <= {auto, 1'b1};
      else if (d == 8'h00)
        {sec, auto} <= 2'b00;
      // a full unlock sequence precedes program, autoselect and secure entry
      else if (step == 2'h2 && wa == 19'h555)
        {pgm, auto, sec} <= {d == 8'ha0, auto | d == 8'h90, sec | d == 8'h88};
      if (pgm)
        pgm <= 1'b0;
    end
  end
  // read data by mode
  always_comb
  begin
    if (vfy || pins.vid_req)
      rd = {15'h0, locked | factory_locked};
    else if (query_signature_string)
      rd = (wa >= 19'h10 && wa <= 19'h26) ? QT[wa - 19'h10] : 16'h0;
    // indicator bit seven shows the factory lock
    else if (auto)
      rd = {8'h0, factory_locked, 7'h0e};
    else if (sec)
      rd = inesn ? mem[wa[2:0]] : 16'h5a5a;
    else
      rd = ~wa[15:0];
    // byte bus: even byte low half, odd byte high half
    if (!pins.byte_n)
      rd = {8'h0, pins.addr[0] ? rd[15:8] : rd[7:0]};
  end
  // released bus shows the inverse of the last value so a stale copy never matches
  assign dq = (!pins.ce_n && !pins.oe_n) ? rd : ~last;
  always @(posedge clock)
    last <= (!pins.ce_n && !pins.oe_n) ? rd : last;
endmodule : ssq_flash_model
`default_nettype wire

// *** ssq_host_bench.sv ***
// self-checking testbench for the secure-sector and query host controller
`timescale 1ns/10ps
`default_nettype none
module ssq_host_bench;
  import ssq_pkg::*;
  localparam logic [15:0] QT [23] = '{16'h51, 16'h52, 16'h59, 16'h2, 16'h0, 16'h40, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h0, 16'h27, 16'h36, 16'h0, 16'h0, 16'h3, 16'h0, 16'h9, 16'h0, 16'h5, 16'h0, 16'h4, 16'h0};
  logic        clock, rst, ce, byte_mode, top_boot, factory_locked, cmd_valid;
  logic        cmd_ready, rsp_valid, sec_mode, query_mode, sec_locked;
  ssq_cmd_s    cmd;
  ssq_rsp_s    rsp;
  ssq_pin_s    pins;
  logic [2:0]  esn_idx;
  logic [15:0] esn_data, flash_dq;
  int          mismatches, cmp_count;
  // design and device model
  ssq_host u_ssq_host (.clock(clock), .rst(rst), .ce(ce), .byte_mode(byte_mode), .top_boot(top_boot),
    .factory_locked(factory_locked), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp), .sec_mode(sec_mode), .query_mode(query_mode), .sec_locked(sec_locked),
    .esn_idx(esn_idx), .esn_data(esn_data), .pins(pins), .flash_dq_i(flash_dq));
  ssq_flash_model u_ssq_flash_model (.clock(clock), .top_boot(top_boot), .factory_locked(factory_locked),
    .pins(pins), .dq(flash_dq));
  // 20 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    // an unknown result counts as a mismatch
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  // one command: raise valid after an edge, taken at the next, then wait for the answer
  task automatic do_cmd(input ssq_op_e op, input logic [18:0] a, input logic [15:0] d);
    int n;
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd       <= '{op: op, addr: a, data: d};
    @(posedge clock);
    cmd_valid <= 1'b0;
    for (n = 0; n < 4000 && rsp_valid !== 1'b1; n++)
      @(negedge clock);
    chk(n < 4000, "no response");
  endtask : do_cmd
  task automatic t_query(input logic bm, input logic [18:0] last_a);
    @(posedge clock);
    byte_mode <= bm;
    do_cmd(OP_QUERY, QUERY_ADDR, QUERY_DATA);
    chk(query_mode === 1'b1, "query not entered");
    for (logic [18:0] a = 19'h10; a <= last_a; a++)
    begin
      do_cmd(OP_READ, a, 16'h0);
      chk(rsp.data === QT[a - 19'h10], "bad query word");
    end
    do_cmd(OP_RESET, 19'h0, RESET_DATA);
    do_cmd(OP_READ, 19'h10, 16'h0);
    chk(rsp.data === (bm ? 16'h00ef : 16'hffef), "array not back");
  endtask : t_query
  task automatic t_id_query;
    do_cmd(OP_AUTOSEL, UNLOCK1_ADDR, AUTOSEL_DATA);
    do_cmd(OP_QUERY, QUERY_ADDR, QUERY_DATA);
    do_cmd(OP_RESET, 19'h0, RESET_DATA);
    do_cmd(OP_READ, 19'h3, 16'h0);
    chk(rsp.data === {8'h0, factory_locked, 7'h0e}, "identifier mode lost");
    do_cmd(OP_RESET, 19'h0, RESET_DATA);
    do_cmd(OP_READ, 19'h3, 16'h0);
    chk(rsp.data === (byte_mode ? 16'h00fc : 16'hfffc), "array not back");
  endtask : t_id_query
  // the serial words sit in the secure region, so enter it around the reads
  task automatic t_esn(input logic top, input logic bm);
    @(posedge clock);
    top_boot  <= top;
    byte_mode <= bm;
    do_cmd(OP_SEC_ENTER, UNLOCK1_ADDR, SEC_IN_DATA);
    do_cmd(OP_ESN, 19'h0, 16'h0);
    do_cmd(OP_SEC_EXIT, UNLOCK1_ADDR, SEC_OUT_DATA);
    for (int i = 0; i < ESN_WORDS; i++)
    begin
      @(posedge clock);
      esn_idx <= 3'(i);
      @(posedge clock);
      @(negedge clock);
      chk(esn_data === 16'ha500 + 16'(i), "bad serial word");
    end
  endtask : t_esn
  // program, then lock; later programs and writes are refused
  task automatic t_lock(input logic factory, input logic [15:0] old);
    do_cmd(OP_SEC_ENTER, UNLOCK1_ADDR, SEC_IN_DATA);
    do_cmd(OP_PROGRAM, 19'h1, 16'h1234);
    chk(rsp.err === factory, "program refusal wrong");
    do_cmd(OP_READ, 19'h1, 16'h0);
    chk(rsp.data === old, "secure word wrong");
    do_cmd(OP_SEC_EXIT, UNLOCK1_ADDR, SEC_OUT_DATA);
    chk(sec_mode === 1'b0, "region not left");
    do_cmd(OP_LOCK, SEC_GRP_ADDR, PROT_DATA);
    chk(rsp.err === factory && sec_locked === 1'b1, "lock state wrong");
    chk(factory || (rsp.ok === 1'b1 && sec_mode === 1'b0), "lock not verified");
    do_cmd(OP_SEC_ENTER, UNLOCK1_ADDR, SEC_IN_DATA);
    do_cmd(OP_PROGRAM, 19'h1, 16'h0);
    chk(rsp.err === 1'b1, "locked program taken");
    do_cmd(OP_WRITE, 19'h1, 16'h0);
    chk(rsp.err === 1'b1, "locked write taken");
    do_cmd(OP_SEC_EXIT, UNLOCK1_ADDR, SEC_OUT_DATA);
  endtask : t_lock
  // a low clock enable freezes the port: the request waits and is taken once enabled
  task automatic t_freeze;
    int n;
    @(posedge clock);
    ce        <= 1'b0;
    cmd_valid <= 1'b1;
    cmd       <= '{op: OP_READ, addr: 19'h3, data: 16'h0};
    repeat (3) @(posedge clock);
    ce <= 1'b1;
    @(negedge clock);
    chk(cmd_ready === 1'b1 && rsp_valid === 1'b0 && pins.ce_n === 1'b1, "state moved while frozen");
    @(posedge clock);
    cmd_valid <= 1'b0;
    for (n = 0; n < 40 && rsp_valid !== 1'b1; n++)
      @(negedge clock);
    chk(n < 40 && rsp.data === 16'hfffc, "read after freeze wrong");
  endtask : t_freeze
  task automatic complete_run;
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // main sequence: factory part first, then a second reset as a customer part
  initial
  begin
    {rst, ce, factory_locked} = 3'b111;
    {byte_mode, top_boot, cmd_valid} = 3'b000;
    {cmd, esn_idx, mismatches, cmp_count} = '0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_query(1'b0, 19'h26);
    t_query(1'b1, 19'h12);
    t_id_query;
    t_esn(1'b1, 1'b1);
    t_esn(1'b0, 1'b0);
    t_lock(1'b1, 16'ha501);
    @(posedge clock);
    {factory_locked, rst} <= 2'b01;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_lock(1'b0, 16'h1234);
    t_id_query;
    t_freeze;
    complete_run;
  end
  // watchdog against a hang
  initial
  begin
    repeat (30000) @(posedge clock);
    mismatches++;
    complete_run;
  end
endmodule : ssq_host_bench
bind ssq_host ssq_host_checker u_ssq_host_checker (.clock(clock), .rst(rst), .ce(ce), .byte_mode(byte_mode),
  .factory_locked(factory_locked), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
  .rsp_valid(rsp_valid), .rsp(rsp), .sec_mode(sec_mode), .query_mode(query_mode), .sec_locked(sec_locked),
  .pins(pins));
`default_nettype wire
